// ### inc/ccs_pkg.sv
package ccs_pkg;

   // ---------------------------------------------------------------
   // register offsets on the control port
   // ---------------------------------------------------------------
   localparam logic [7:0] CCS_OFS_FREQ_ROLE = 8'h37;
   localparam logic [7:0] CCS_OFS_PRI_CFG = 8'h38;
   localparam logic [7:0] CCS_OFS_PRI_LOW = 8'h39;
   localparam logic [7:0] CCS_OFS_SEC_CFG = 8'h3A;
   localparam logic [7:0] CCS_OFS_SEC_LOW = 8'h3B;
   localparam logic [7:0] CCS_OFS_ERR_FLAGS = 8'h3C;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CCS_RST_FREQ_ROLE = 8'h20;
   localparam logic [7:0] CCS_RST_CFG = 8'h00;
   localparam logic [2:0] CCS_RST_FREQ_SEL = 3'h1;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CCS_FREQ_LSB = 5;
   localparam int CCS_FREQ_MSB = 7;
   localparam int CCS_PRI_ROLE_BIT = 4;
   localparam int CCS_SEC_ROLE_BIT = 3;
   localparam int CCS_FAMILY_BIT = 0;
   localparam int CCS_INT_SEL_BIT = 7;
   localparam int CCS_INV_BIT = 6;
   localparam int CCS_HIGH_MSB = 5;
   localparam int CCS_ERR_RATIO_BIT = 7;
   localparam int CCS_ERR_CONV_BIT = 4;
   localparam int CCS_ERR_MOD_BIT = 3;
   localparam int CCS_ERR_PDM_BIT = 2;
   localparam int CCS_ERR_STOP_BIT = 1;

   // writable bits of the frequency/role and config registers; the rest read as zero
   localparam logic [7:0] CCS_MASK_FREQ_ROLE = 8'hF9;
   localparam logic [7:0] CCS_MASK_CFG = 8'hFF;

   // ---------------------------------------------------------------
   // clock source selection and ratio width
   // ---------------------------------------------------------------
   localparam logic [2:0] CCS_SRC_FIXED_REF = 3'h4;
   localparam int CCS_RATIO_W = 14;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CCS_CLK_PERIOD_NS = 10;
   localparam int CCS_STOP_TIME_US = 1;
   localparam int CCS_STOP_TIME_MS = 1;
   // least time, so round up
   localparam int CCS_STOP_CYCLES =
      (CCS_STOP_TIME_MS * 1000000 + CCS_CLK_PERIOD_NS - 1) / CCS_CLK_PERIOD_NS;

endpackage : ccs_pkg

// ### verilog/ccs_fsync_gen.sv
`timescale 1ns/1ns
module ccs_fsync_gen #(
   parameter int RATIO_W = 14
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic useInternal,
   input wire logic invert,
   input wire logic intBitClk,
   input wire logic extBitClk,
   input wire logic [RATIO_W-1:0] ratio,
   output logic fsync
);

   // ---------------------------------------------------------------
   // chosen bit clock and its rising edge
   // ---------------------------------------------------------------
   logic srcClk;
   logic prevClk_q;
   logic clkEdge;
   logic [RATIO_W-1:0] count_q;
   logic fsync_q;

   // inversion touches only this copy, not the port's own bit clock
   assign srcClk = (useInternal ? intBitClk : extBitClk) ^ invert;
   assign clkEdge = srcClk & ~prevClk_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prevClk_q <= 1'b0;
      end else begin
         prevClk_q <= srcClk;
      end
   end

   // ---------------------------------------------------------------
   // divide by ratio; zero ratio keeps the sync idle
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst || !enable || ratio == '0) begin
         count_q <= '0;
         fsync_q <= 1'b0;
      end else if (clkEdge) begin
         fsync_q <= (count_q == '0);
         if (count_q >= ratio - 1'b1) begin
            count_q <= '0;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   assign fsync = fsync_q;

endmodule : ccs_fsync_gen

// ### verilog/ccs_stop_detect.sv
`timescale 1ns/1ns
module ccs_stop_detect #(
   parameter int STOP_CYCLES = 100000
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic audioClk,
   output logic stopped
);

   // ---------------------------------------------------------------
   // idle counter, restarted by every audio clock edge
   // ---------------------------------------------------------------
   localparam int CW = $clog2(STOP_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(STOP_CYCLES - 1);

   logic prevClk_q;
   logic [CW-1:0] idle_q;
   logic stopped_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prevClk_q <= 1'b0;
      end else begin
         prevClk_q <= audioClk;
      end
   end

   // any change of level counts as activity, so either edge clears
   always_ff @(posedge ref_clk) begin
      if (rst || audioClk != prevClk_q) begin
         idle_q <= '0;
         stopped_q <= 1'b0;
      end else if (idle_q == LAST) begin
         stopped_q <= 1'b1;
      end else begin
         idle_q <= idle_q + 1'b1;
      end
   end

   assign stopped = stopped_q;

endmodule : ccs_stop_detect

// ### verilog/ccs_clock_config.sv
`timescale 1ns/1ns
// Overview of operation
// - three-bit reference frequency code, 12 to 24.576 MHz, resets to code one
// - primary port role bit: clear is target, set is controller, resets target
// - secondary port role bit: clear is target, set is controller, resets target
// - rate family bit for both ports in controller mode: 48k or 44.1k
// - primary controller frame sync uses internal bit clock when set, else external
// - primary polarity bit inverts bit clock for frame-sync generation only
// - primary ratio is 14 bits: six high bits plus low byte, reset zero
// - secondary controller frame sync uses internal bit clock when set, else external
// - secondary polarity bit inverts bit clock for its frame-sync generation only
// - secondary ratio is 14 bits: six high bits plus low byte, reset zero
// - bit 7 flags wrong frame sync to clock source ratio, clear otherwise
// - bit 4 flags unsupported converter ratio; meaningless with custom ratio
// - bit 3 flags no valid modulator clock rate in chosen configuration
// - bit 2 flags no valid PDM clock in chosen configuration
// - bit 1 flags audio clock stopped one millisecond, clear while running
// - clock source code four is fixed reference, only usable in controller mode
module ccs_clock_config
   import ccs_pkg::*;
#(
   parameter int STOP_CYCLES = CCS_STOP_CYCLES,
   parameter int RATIO_W = CCS_RATIO_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   // control port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // bit clocks seen by the serial ports
   input wire logic primaryIntBitClk,
   input wire logic primaryExtBitClk,
   input wire logic secondaryIntBitClk,
   input wire logic secondaryExtBitClk,
   // audio clock source and its selection code
   input wire logic audioClkSrc,
   input wire logic [2:0] clockSourceSelect,
   // fault detectors of the clock tree
   input wire logic ratioFault,
   input wire logic converterFault,
   input wire logic modulatorFault,
   input wire logic pdmFault,
   // configuration towards the clock tree
   output logic [2:0] refFreqSelect,
   output logic [15:0] refFreqKhz,
   output logic primaryRole,
   output logic secondaryRole,
   output logic rateFamily,
   output logic fixedRefUsable,
   // generated frame syncs
   output logic primaryFsync,
   output logic secondaryFsync
);

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [7:0] freqRole_q;
   logic [7:0] priCfg_q;
   logic [7:0] priLow_q;
   logic [7:0] secCfg_q;
   logic [7:0] secLow_q;
   logic [7:0] errFlags_q;
   logic [7:0] rdData_q;
   logic [15:0] refFreqKhz_q;
   logic fixedRefUsable_q;
   logic clockStopped;
   logic [7:0] rdMux;
   logic [RATIO_W-1:0] primaryRatio;
   logic [RATIO_W-1:0] secondaryRatio;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // write strobe for one offset
   function automatic logic wrHit(input logic [7:0] ofs);
      wrHit = regWrite && (regAddr == ofs);
   endfunction : wrHit

   // reference frequency code to kHz, rounded down
   function automatic logic [15:0] freqKhz(input logic [2:0] code);
      case (code)
         3'h0: freqKhz = 16'h2EE0;
         3'h1: freqKhz = 16'h3000;
         3'h2: freqKhz = 16'h32C8;
         3'h3: freqKhz = 16'h3E80;
         3'h4: freqKhz = 16'h4B00;
         3'h5: freqKhz = 16'h4CE0;
         3'h6: freqKhz = 16'h5DC0;
         3'h7: freqKhz = 16'h6000;
         default: freqKhz = 16'h3000;
      endcase
   endfunction : freqKhz

   // ---------------------------------------------------------------
   // frequency, roles and rate family
   // ---------------------------------------------------------------

   // reserved positions are masked so they always read back zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         freqRole_q <= CCS_RST_FREQ_ROLE;
      end else if (wrHit(CCS_OFS_FREQ_ROLE)) begin
         freqRole_q <= regWrData & CCS_MASK_FREQ_ROLE;
      end
   end

   assign refFreqSelect = freqRole_q[CCS_FREQ_MSB:CCS_FREQ_LSB];
   assign primaryRole = freqRole_q[CCS_PRI_ROLE_BIT];
   assign secondaryRole = freqRole_q[CCS_SEC_ROLE_BIT];

   // family only matters when some port drives its own clocks
   assign rateFamily = freqRole_q[CCS_FAMILY_BIT] & (primaryRole | secondaryRole);

   // decoded frequency kept in a flop so the output is clean
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         refFreqKhz_q <= freqKhz(CCS_RST_FREQ_SEL);
      end else begin
         refFreqKhz_q <= freqKhz(refFreqSelect);
      end
   end

   assign refFreqKhz = refFreqKhz_q;

   // ---------------------------------------------------------------
   // fixed reference qualification
   // ---------------------------------------------------------------

   // a fixed reference is meaningless for a pure target setup
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fixedRefUsable_q <= 1'b0;
      end else begin
         fixedRefUsable_q <= (clockSourceSelect == CCS_SRC_FIXED_REF)
            && (primaryRole || secondaryRole);
      end
   end

   assign fixedRefUsable = fixedRefUsable_q;

   // ---------------------------------------------------------------
   // primary port frame-sync configuration
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         priCfg_q <= CCS_RST_CFG;
      end else if (wrHit(CCS_OFS_PRI_CFG)) begin
         priCfg_q <= regWrData & CCS_MASK_CFG;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         priLow_q <= CCS_RST_CFG;
      end else if (wrHit(CCS_OFS_PRI_LOW)) begin
         priLow_q <= regWrData;
      end
   end

   // the two halves may be written in any order; ratio follows at once
   assign primaryRatio = {priCfg_q[CCS_HIGH_MSB:0], priLow_q};

   // ---------------------------------------------------------------
   // secondary port frame-sync configuration
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         secCfg_q <= CCS_RST_CFG;
      end else if (wrHit(CCS_OFS_SEC_CFG)) begin
         secCfg_q <= regWrData & CCS_MASK_CFG;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         secLow_q <= CCS_RST_CFG;
      end else if (wrHit(CCS_OFS_SEC_LOW)) begin
         secLow_q <= regWrData;
      end
   end

   assign secondaryRatio = {secCfg_q[CCS_HIGH_MSB:0], secLow_q};

   // ---------------------------------------------------------------
   // frame-sync generators
   // ---------------------------------------------------------------

   // each runs only while its port is controller
   ccs_fsync_gen #(
      .RATIO_W(RATIO_W)
   ) primaryGen (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(primaryRole),
      .useInternal(priCfg_q[CCS_INT_SEL_BIT]),
      .invert(priCfg_q[CCS_INV_BIT]),
      .intBitClk(primaryIntBitClk),
      .extBitClk(primaryExtBitClk),
      .ratio(primaryRatio),
      .fsync(primaryFsync)
   );

   ccs_fsync_gen #(
      .RATIO_W(RATIO_W)
   ) secondaryGen (
      .ref_clk(ref_clk),
      .rst(rst),
      .enable(secondaryRole),
      .useInternal(secCfg_q[CCS_INT_SEL_BIT]),
      .invert(secCfg_q[CCS_INV_BIT]),
      .intBitClk(secondaryIntBitClk),
      .extBitClk(secondaryExtBitClk),
      .ratio(secondaryRatio),
      .fsync(secondaryFsync)
   );

   // ---------------------------------------------------------------
   // clock stop watch
   // ---------------------------------------------------------------
   ccs_stop_detect #(
      .STOP_CYCLES(STOP_CYCLES)
   ) stopWatch (
      .ref_clk(ref_clk),
      .rst(rst),
      .audioClk(audioClkSrc),
      .stopped(clockStopped)
   );

   // ---------------------------------------------------------------
   // error flags
   // ---------------------------------------------------------------

   // flags track their cause, so they clear by themselves once the
   // fault is gone; a reader sees the state of the previous cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         errFlags_q <= CCS_RST_CFG;
      end else begin
         errFlags_q <= '0;
         errFlags_q[CCS_ERR_RATIO_BIT] <= ratioFault;
         errFlags_q[CCS_ERR_CONV_BIT] <= converterFault;
         errFlags_q[CCS_ERR_MOD_BIT] <= modulatorFault;
         errFlags_q[CCS_ERR_PDM_BIT] <= pdmFault;
         errFlags_q[CCS_ERR_STOP_BIT] <= clockStopped;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------

   // unmapped offsets read zero; reserved bits are already zero
   always_comb begin
      case (regAddr)
         CCS_OFS_FREQ_ROLE: rdMux = freqRole_q;
         CCS_OFS_PRI_CFG: rdMux = priCfg_q;
         CCS_OFS_PRI_LOW: rdMux = priLow_q;
         CCS_OFS_SEC_CFG: rdMux = secCfg_q;
         CCS_OFS_SEC_LOW: rdMux = secLow_q;
         CCS_OFS_ERR_FLAGS: rdMux = errFlags_q;
         default: rdMux = 8'h00;
      endcase
   end

   // read data held until the next read strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdData_q <= 8'h00;
      end else if (regRead) begin
         rdData_q <= rdMux;
      end
   end

   assign regRdData = rdData_q;

endmodule : ccs_clock_config

// ### sim/ccs_host_model.sv
`timescale 1ns/1ns
// far-end bit clock; stands still low while no frame traffic runs
module ccs_host_model #(
   parameter int HALF = 3
) (
   input wire logic ref_clk,
   input wire logic run,
   output logic bitClk
);
   int cnt;
   initial bitClk = 1'b0;
   // toggles off the sampling edge, every HALF cycles
   always @(negedge ref_clk) begin
      if (!run) begin
         cnt <= 0;
         bitClk <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         bitClk <= ~bitClk;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : ccs_host_model

// ### sim/ccs_clock_config_chk.sv
`timescale 1ns/1ns
module ccs_clock_config_chk
   import ccs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic [2:0] clockSourceSelect,
   input wire logic ratioFault,
   input wire logic converterFault,
   input wire logic modulatorFault,
   input wire logic pdmFault,
   input wire logic [2:0] refFreqSelect,
   input wire logic [15:0] refFreqKhz,
   input wire logic primaryRole,
   input wire logic secondaryRole,
   input wire logic rateFamily,
   input wire logic fixedRefUsable,
   input wire logic primaryFsync,
   input wire logic secondaryFsync
);
   // kHz per frequency code, kept apart from the design's decoder
   localparam logic [15:0] KHZ [0:7] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80,
      16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   rst_state_a:
   assert property (@(posedge ref_clk) disable iff (1'b0) rst |=> refFreqSelect == 3'h1
      && !primaryRole && !secondaryRole && !primaryFsync && !secondaryFsync)
      else $error("reset state wrong");
   role_write_a:
   assert property (regWrite && regAddr == CCS_OFS_FREQ_ROLE |=> primaryRole ==
      $past(regWrData[4]) && secondaryRole == $past(regWrData[3])
      && refFreqSelect == $past(regWrData[7:5])) else $error("role write lost");
   family_gate_a:
   assert property (rateFamily |-> primaryRole || secondaryRole)
      else $error("family without controller");
   freq_decode_a:
   assert property (refFreqKhz == KHZ[$past(refFreqSelect)]) else $error("bad kHz");
   fixed_ref_a:
   assert property (fixedRefUsable == $past(clockSourceSelect == 3'h4
      && (primaryRole || secondaryRole))) else $error("fixed ref wrong");
   reserved_zero_a:
   assert property (regRead && regAddr == CCS_OFS_FREQ_ROLE |=> regRdData[2:1] == 2'h0)
      else $error("reserved bits set");
   flag_read_a:
   assert property (regRead && regAddr == CCS_OFS_ERR_FLAGS |=> regRdData[7] ==
      $past(ratioFault, 2) && regRdData[4] == $past(converterFault, 2)
      && regRdData[3] == $past(modulatorFault, 2) && regRdData[2] == $past(pdmFault, 2)
      && regRdData[6] == 1'b0 && regRdData[5] == 1'b0 && regRdData[0] == 1'b0)
      else $error("flag read wrong");
   sync_off_a:
   assert property ((!primaryRole |=> !primaryFsync) and (!secondaryRole |=> !secondaryFsync))
      else $error("sync while target");
   rd_hold_a:
   assert property (!regRead |=> $stable(regRdData)) else $error("read data moved");

   cover property ($rose(primaryFsync));
   cover property ($rose(secondaryFsync));
   cover property (fixedRefUsable);
endmodule : ccs_clock_config_chk

bind ccs_clock_config ccs_clock_config_chk u_chk (.ref_clk(ref_clk), .rst(rst),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .clockSourceSelect(clockSourceSelect), .ratioFault(ratioFault),
   .converterFault(converterFault), .modulatorFault(modulatorFault), .pdmFault(pdmFault),
   .refFreqSelect(refFreqSelect), .refFreqKhz(refFreqKhz), .primaryRole(primaryRole),
   .secondaryRole(secondaryRole), .rateFamily(rateFamily), .fixedRefUsable(fixedRefUsable),
   .primaryFsync(primaryFsync), .secondaryFsync(secondaryFsync));

// ### sim/tb.sv
`timescale 1ns/1ns
module tb;
   import ccs_pkg::*;
   logic ref_clk, rst, regWrite, regRead, hostRun, audioRun, extP, extS, audioClk;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [2:0] clockSourceSelect, refFreqSelect;
   logic [3:0] fault;
   logic [1:0] intDiv = 2'h0;
   logic [15:0] refFreqKhz;
   logic primaryRole, secondaryRole, rateFamily, fixedRefUsable, primaryFsync, secondaryFsync;
   int fail_count, checked;
   localparam logic [15:0] KHZ_EXP [0:7] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80,
      16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};
   localparam logic [7:0] FLAG_EXP [0:3] = '{8'h80, 8'h10, 8'h08, 8'h04};

   // short stop count keeps the clock-stop case quick
   ccs_clock_config #(.STOP_CYCLES(20)) uut (.ref_clk(ref_clk), .rst(rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .primaryIntBitClk(intDiv[1]), .primaryExtBitClk(extP),
      .secondaryIntBitClk(intDiv[1]), .secondaryExtBitClk(extS), .audioClkSrc(audioClk),
      .clockSourceSelect(clockSourceSelect), .ratioFault(fault[0]),
      .converterFault(fault[1]), .modulatorFault(fault[2]), .pdmFault(fault[3]),
      .refFreqSelect(refFreqSelect), .refFreqKhz(refFreqKhz), .primaryRole(primaryRole),
      .secondaryRole(secondaryRole), .rateFamily(rateFamily),
      .fixedRefUsable(fixedRefUsable), .primaryFsync(primaryFsync),
      .secondaryFsync(secondaryFsync));
   ccs_host_model #(.HALF(3)) priHost (.ref_clk(ref_clk), .run(hostRun), .bitClk(extP));
   ccs_host_model #(.HALF(4)) secHost (.ref_clk(ref_clk), .run(hostRun), .bitClk(extS));
   ccs_host_model #(.HALF(2)) audSrc (.ref_clk(ref_clk), .run(audioRun), .bitClk(audioClk));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // internal bit clock, four reference cycles a period
   always @(negedge ref_clk) begin
      intDiv <= intDiv + 2'h1;
   end

   // -------------------------------------------
   // access and compare tasks
   // -------------------------------------------
   task results;
      if (fail_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : cmp
   task cmpN(input int got, input int exp);
      checked++;
      if (got != exp) begin
         $display("[FAIL] %0t period %0d expected %0d", $time, got, exp);
         fail_count++;
      end
   endtask : cmpN
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge ref_clk);
      regWrite = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge ref_clk);
      regRead = 1'b0;
      @(negedge ref_clk);
      cmp(16'(regRdData), 16'(e));
   endtask : rd
   task waitN(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : waitN
   // skip a settling period, then measure one full frame in cycles
   task period(input bit sec, input int exp);
      int n, rises;
      logic p, c;
      n = 0;
      rises = 0;
      p = 1'b1;
      for (int i = 0; i < 4000 && rises < 3; i++) begin
         @(posedge ref_clk);
         #1;
         c = sec ? secondaryFsync : primaryFsync;
         n++;
         if (c === 1'b1 && p === 1'b0) begin
            rises++;
            if (rises < 3) n = 0;
         end
         p = c;
      end
      cmpN(n, exp);
   endtask : period

   // -------------------------------------------
   // test sequence
   // -------------------------------------------
   initial begin
      {rst, regWrite, regRead, hostRun, audioRun} = 5'h13;
      {regAddr, regWrData, clockSourceSelect, fault} = 23'h0;
      fail_count = 0;
      checked = 0;
      waitN(8);
      rst = 1'b0;
      rd(8'h37, 8'h20);
      for (int a = 8'h38; a <= 8'h3C; a++) rd(8'(a), 8'h00);
      cmp(refFreqKhz, 16'h3000);
      for (int c = 0; c < 8; c++) begin
         wr(8'h37, {3'(c), 5'h00});
         rd(8'h37, {3'(c), 5'h00});
         cmp(refFreqKhz, KHZ_EXP[c]);
      end
      wr(8'h37, 8'hFF);
      rd(8'h37, 8'hF9);
      cmp({14'h0, primaryRole, secondaryRole}, 16'h3);
      cmp(16'(rateFamily), 16'h1);
      wr(8'h37, 8'h01);
      cmp(16'(rateFamily), 16'h0);
      wr(8'h3C, 8'hFF);
      rd(8'h3C, 8'h00);
      rd(8'h40, 8'h00);
      clockSourceSelect = 3'h4;
      wr(8'h37, 8'h10);
      waitN(2);
      cmp(16'(fixedRefUsable), 16'h1);
      wr(8'h37, 8'h08);
      clockSourceSelect = 3'h3;
      waitN(2);
      cmp(16'(fixedRefUsable), 16'h0);
      // frame sync from both ports as controllers
      hostRun = 1'b1;
      wr(8'h37, 8'h18);
      wr(8'h38, 8'h80);
      wr(8'h39, 8'h04);
      period(1'b0, 16);
      wr(8'h38, 8'hC0);
      period(1'b0, 16);
      wr(8'h38, 8'h00);
      period(1'b0, 24);
      wr(8'h38, 8'h81);
      wr(8'h39, 8'h00);
      period(1'b0, 1024);
      wr(8'h3B, 8'h03);
      period(1'b1, 24);
      wr(8'h3A, 8'hC0);
      period(1'b1, 12);
      wr(8'h37, 8'h00);
      for (int i = 0; i < 40; i++) begin
         waitN(1);
         cmp({14'h0, primaryFsync, secondaryFsync}, 16'h0);
      end
      for (int i = 0; i < 4; i++) begin
         fault = 4'(1 << i);
         waitN(2);
         rd(8'h3C, FLAG_EXP[i]);
      end
      fault = 4'h0;
      audioRun = 1'b0;
      waitN(40);
      rd(8'h3C, 8'h02);
      audioRun = 1'b1;
      waitN(5);
      rd(8'h3C, 8'h00);
      wr(8'h37, 8'h18);
      rst = 1'b1;
      waitN(2);
      rst = 1'b0;
      rd(8'h37, 8'h20);
      results();
   end

   // hang guard, well beyond the expected run
   initial begin
      #300000;
      fail_count++;
      results();
   end
endmodule : tb
